/* rtl/ldc_pkg.sv */
package ldc_pkg;
    // =========================================================
    // register offsets (7-bit serial address)
    localparam logic [6:0] LDC_OFS_LASER_CONTROL_PRIMARY      = 7'h1a;
    localparam logic [6:0] LDC_OFS_LASER_CURRENT_CODE         = 7'h1c;
    localparam logic [6:0] LDC_OFS_LASER_CURRENT_CODE_INVERSE = 7'h1d;
    localparam logic [6:0] LDC_OFS_LASER_RANGE_INVERSE        = 7'h1f;
    localparam logic [6:0] LDC_OFS_MOTION                     = 7'h02;
    localparam logic [6:0] LDC_OFS_MOTION_ALIAS               = 7'h42;
    // =========================================================
    // field positions
    localparam int LDC_RANGE_MSB   = 7;
    localparam int LDC_RANGE_LSB   = 6;
    localparam int LDC_CAL_MSB     = 3;
    localparam int LDC_CAL_LSB     = 1;
    localparam int LDC_FORCE_BIT   = 0;
    // =========================================================
    // field codes and reset values
    localparam logic [1:0] LDC_BAND_LOW      = 2'h0;
    localparam logic [1:0] LDC_BAND_MID      = 2'h1;
    localparam logic [1:0] LDC_BAND_BAD      = 2'h2;
    localparam logic [1:0] LDC_BAND_HIGH     = 2'h3;
    localparam logic [2:0] LDC_CAL_CW        = 3'h5;
    localparam logic [2:0] LDC_CAL_OFF       = 3'h0;
    localparam logic [7:0] LDC_RESET_VALUE   = 8'h00;
    localparam logic [7:0] LDC_UNMAPPED_READ = 8'h00;
endpackage

/* rtl/ldc_pair_check.sv */
`timescale 1ns/100ps
// =========================================================
// complement pair compare
module ldc_pair_check #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] i_value,
    input  wire logic [WIDTH-1:0] i_inverse,
    output logic                  o_ok
);
    assign o_ok = (i_value == ~i_inverse);
endmodule

/* rtl/ldc_laser_drive_control.sv */
// Operation
// - range bits mismatch complement: laser off, flag cleared
// - range code selects laser current band
// - range code 10 invalid: laser off, flag cleared
// - calibration field 101b gives continuous-on laser
// - calibration field 000b returns to pulsed mode
// - motion register read clears calibration field
// - force-off bit holds active-low enable high
// - current code mismatch complement: laser off, flag cleared
// - eight-bit code drives current dac
// - current pair writable in either order
// - range pair writable in either order
`timescale 1ns/100ps
module ldc_laser_drive_control
    import ldc_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    input  wire logic [6:0]        i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_laser_pulse,
    output logic [DATA_W-1:0]      o_rdata,
    output logic                   o_laser_drive_low_enable_n,
    output logic                   o_laser_setting_ok_flag,
    output logic [1:0]             o_current_band,
    output logic [DATA_W-1:0]      o_current_dac_code,
    output logic                   o_continuous_on
);

    // =========================================================
    // register state
    logic [1:0]        range_q,      range_d;
    logic [2:0]        cal_q,        cal_d;
    logic              force_q,      force_d;
    logic [DATA_W-1:0] code_q,       code_d;
    logic [DATA_W-1:0] code_inv_q,   code_inv_d;
    logic [1:0]        range_inv_q,  range_inv_d;
    logic [DATA_W-1:0] rdata_q,      rdata_d;
    logic              laser_n_q,    laser_n_d;
    logic              ok_q,         ok_d;
    logic [1:0]        band_q,       band_d;
    logic [DATA_W-1:0] dac_q,        dac_d;
    logic              cw_q,         cw_d;
    logic              range_ok;
    logic              code_ok;
    logic              setting_ok;
    logic              motion_read;

    function automatic logic hit(input logic [6:0] addr, input logic [6:0] ofs);
        hit = (addr == ofs);
    endfunction

    // =========================================================
    // complement checks, evaluated on live contents
    ldc_pair_check #(.WIDTH(2)) u_range_check (
        .i_value   (range_q),
        .i_inverse (range_inv_q),
        .o_ok      (range_ok)
    );

    ldc_pair_check #(.WIDTH(DATA_W)) u_code_check (
        .i_value   (code_q),
        .i_inverse (code_inv_q),
        .o_ok      (code_ok)
    );

    assign setting_ok  = range_ok && code_ok && (range_q != LDC_BAND_BAD);
    assign motion_read = i_rd_en && (hit(i_addr, LDC_OFS_MOTION) || hit(i_addr, LDC_OFS_MOTION_ALIAS));

    // =========================================================
    // register writes and reads
    always_comb
    begin
        range_d     = range_q;
        cal_d       = cal_q;
        force_d     = force_q;
        code_d      = code_q;
        code_inv_d  = code_inv_q;
        range_inv_d = range_inv_q;
        rdata_d     = rdata_q;
        // motion read leaves calibration; a same-cycle write below wins
        if (motion_read)
        begin
            cal_d = LDC_CAL_OFF;
        end
        if (i_wr_en)
        begin
            if (hit(i_addr, LDC_OFS_LASER_CONTROL_PRIMARY))
            begin
                range_d = i_wdata[LDC_RANGE_MSB:LDC_RANGE_LSB];
                cal_d   = i_wdata[LDC_CAL_MSB:LDC_CAL_LSB];
                force_d = i_wdata[LDC_FORCE_BIT];
            end
            if (hit(i_addr, LDC_OFS_LASER_CURRENT_CODE))
            begin
                code_d = i_wdata;
            end
            if (hit(i_addr, LDC_OFS_LASER_CURRENT_CODE_INVERSE))
            begin
                code_inv_d = i_wdata;
            end
            if (hit(i_addr, LDC_OFS_LASER_RANGE_INVERSE))
            begin
                range_inv_d = i_wdata[LDC_RANGE_MSB:LDC_RANGE_LSB];
            end
        end
        if (i_rd_en)
        begin
            // reserved bits read zero
            rdata_d = LDC_UNMAPPED_READ;
            if (hit(i_addr, LDC_OFS_LASER_CONTROL_PRIMARY))
            begin
                rdata_d[LDC_RANGE_MSB:LDC_RANGE_LSB] = range_q;
                rdata_d[LDC_CAL_MSB:LDC_CAL_LSB]     = cal_q;
                rdata_d[LDC_FORCE_BIT]               = force_q;
            end
            else if (hit(i_addr, LDC_OFS_LASER_CURRENT_CODE))
            begin
                rdata_d = code_q;
            end
            else if (hit(i_addr, LDC_OFS_LASER_CURRENT_CODE_INVERSE))
            begin
                rdata_d = code_inv_q;
            end
            else if (hit(i_addr, LDC_OFS_LASER_RANGE_INVERSE))
            begin
                rdata_d[LDC_RANGE_MSB:LDC_RANGE_LSB] = range_inv_q;
            end
        end
    end

    // =========================================================
    // laser drive
    always_comb
    begin
        ok_d      = setting_ok;
        cw_d      = (cal_q == LDC_CAL_CW);
        // dac and band frozen at last good pair so a half-written pair never reaches the pin
        band_d    = setting_ok ? range_q : band_q;
        dac_d     = setting_ok ? code_q : dac_q;
        laser_n_d = 1'b1;
        if (setting_ok && !force_q && (cw_d || i_laser_pulse))
        begin
            laser_n_d = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            range_q     <= LDC_RESET_VALUE[1:0];
            cal_q       <= LDC_RESET_VALUE[2:0];
            force_q     <= 1'b0;
            code_q      <= LDC_RESET_VALUE;
            code_inv_q  <= LDC_RESET_VALUE;
            range_inv_q <= LDC_RESET_VALUE[1:0];
            rdata_q     <= LDC_RESET_VALUE;
            laser_n_q   <= 1'b1;
            ok_q        <= 1'b0;
            band_q      <= LDC_BAND_LOW;
            dac_q       <= LDC_RESET_VALUE;
            cw_q        <= 1'b0;
        end
        else
        begin
            range_q     <= range_d;
            cal_q       <= cal_d;
            force_q     <= force_d;
            code_q      <= code_d;
            code_inv_q  <= code_inv_d;
            range_inv_q <= range_inv_d;
            rdata_q     <= rdata_d;
            laser_n_q   <= laser_n_d;
            ok_q        <= ok_d;
            band_q      <= band_d;
            dac_q       <= dac_d;
            cw_q        <= cw_d;
        end
    end

    assign o_rdata                    = rdata_q;
    assign o_laser_drive_low_enable_n = laser_n_q;
    assign o_laser_setting_ok_flag    = ok_q;
    assign o_current_band             = band_q;
    assign o_current_dac_code         = dac_q;
    assign o_continuous_on            = cw_q;

    // =========================================================
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    range_mismatch_a: assert property (!range_ok |=> !o_laser_setting_ok_flag && o_laser_drive_low_enable_n)
        else $error("range mismatch left laser on");
    band_follow_a: assert property (setting_ok |=> o_current_band == $past(range_q))
        else $error("band output not the range code");
    invalid_band_a: assert property (range_q == LDC_BAND_BAD
        |=> !o_laser_setting_ok_flag && o_laser_drive_low_enable_n)
        else $error("invalid range code accepted");
    cal_write_a: assert property (i_wr_en && i_addr == LDC_OFS_LASER_CONTROL_PRIMARY
        && i_wdata[LDC_CAL_MSB:LDC_CAL_LSB] == LDC_CAL_CW ##1 setting_ok && !force_q
        |=> o_continuous_on && !o_laser_drive_low_enable_n)
        else $error("continuous-on not entered");
    cal_exit_a: assert property (i_wr_en && i_addr == LDC_OFS_LASER_CONTROL_PRIMARY
        && i_wdata[LDC_CAL_MSB:LDC_CAL_LSB] == LDC_CAL_OFF
        |=> ##1 !o_continuous_on)
        else $error("calibration not left");
    motion_clear_a: assert property (motion_read && !(i_wr_en && i_addr == LDC_OFS_LASER_CONTROL_PRIMARY)
        |=> cal_q == LDC_CAL_OFF ##1 !o_continuous_on)
        else $error("motion read did not clear calibration");
    force_off_a: assert property (force_q |=> o_laser_drive_low_enable_n)
        else $error("force-off did not hold enable high");
    code_mismatch_a: assert property (!code_ok |=> !o_laser_setting_ok_flag && o_laser_drive_low_enable_n)
        else $error("current code mismatch left laser on");
    dac_follow_a: assert property (setting_ok |=> o_current_dac_code == $past(code_q))
        else $error("dac code not applied");
    pair_order_a: assert property (range_ok && code_ok && range_q != LDC_BAND_BAD
        |=> o_laser_setting_ok_flag)
        else $error("consistent pairs not accepted");
    reset_off_a: assert property ($rose(i_rst_n) |-> o_laser_drive_low_enable_n && !o_laser_setting_ok_flag)
        else $error("laser not off after reset");

    cw_seen_c:      cover property (o_continuous_on && !o_laser_drive_low_enable_n);
    pulsed_seen_c:  cover property (!o_continuous_on && !o_laser_drive_low_enable_n);
    bad_band_c:     cover property (range_ok && code_ok && range_q == LDC_BAND_BAD);
    motion_exit_c:  cover property (cw_q && motion_read ##2 !o_continuous_on);
endmodule

/* verification/ldc_mcu_model.sv */
`timescale 1ns/100ps
// =========================================================
// host model: byte strobes of the serial port
module ldc_mcu_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [6:0]      o_addr,
    output logic [7:0]      o_wdata
);
    initial
    begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 7'h00;
        o_wdata = 8'h00;
    end
    // current pair goes in either order, range pair primary first; cal field only ever gets 101b or 000b
    // strobes change on a rising edge; returns at the edge that samples the write
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        begin
            @(posedge i_clock);
            o_addr  <= a;
            o_wdata <= d;
            o_wr_en <= 1'b1;
            @(posedge i_clock);
            o_wr_en <= 1'b0;
            o_wdata <= ~d;
        end
    endtask
    // data lands one edge after the strobe edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        begin
            @(posedge i_clock);
            o_addr  <= a;
            o_rd_en <= 1'b1;
            @(posedge i_clock);
            o_rd_en <= 1'b0;
            @(posedge i_clock);
            d = i_rdata;
        end
    endtask
endmodule

/* verification/ldc_laser_drive_control_tb_top.sv */
`timescale 1ns/100ps
module ldc_laser_drive_control_tb_top;
    import ldc_pkg::*;
    logic       i_clock, i_rst_n, i_laser_pulse, wr, rd, ok, ln, cw;
    logic [6:0] addr;
    logic [7:0] wd, rdat, dac, v;
    logic [1:0] band, r, lastb;
    int         fail_count, cmp_count;
    // =========================================================
    // instances
    ldc_mcu_model u_mcu (.i_clock(i_clock), .i_rdata(rdat), .o_wr_en(wr), .o_rd_en(rd),
                         .o_addr(addr), .o_wdata(wd));
    ldc_laser_drive_control u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wr_en(wr), .i_rd_en(rd),
        .i_addr(addr), .i_wdata(wd), .i_laser_pulse(i_laser_pulse), .o_rdata(rdat),
        .o_laser_drive_low_enable_n(ln), .o_laser_setting_ok_flag(ok), .o_current_band(band),
        .o_current_dac_code(dac), .o_continuous_on(cw));
    // =========================================================
    // helpers
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic outs(input logic k, input logic l, input logic c, input logic [1:0] b, input logic [7:0] d);
        chk("outs", {3'h0, k, l, c, b, d}, {3'h0, ok, ln, cw, band, dac});
    endtask
    // outputs settle two edges after the write strobe
    task automatic wrs(input logic [6:0] a, input logic [7:0] d);
        u_mcu.wr(a, d);
        @(posedge i_clock);
        #1;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        u_mcu.rd(a, v);
        chk("rdata", {8'h00, e}, {8'h00, v});
    endtask
    task automatic close_out;
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // =========================================================
    // scenarios
    task automatic t_reset;
        outs(1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
        rdc(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h00);
        rdc(LDC_OFS_LASER_CURRENT_CODE, 8'h00);
        rdc(LDC_OFS_LASER_CURRENT_CODE_INVERSE, 8'h00);
        rdc(LDC_OFS_LASER_RANGE_INVERSE, 8'h00);
    endtask
    task automatic t_pairs;
        wrs(LDC_OFS_LASER_CURRENT_CODE, 8'h55);
        wrs(LDC_OFS_LASER_CURRENT_CODE_INVERSE, 8'haa);
        outs(1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
        wrs(LDC_OFS_LASER_RANGE_INVERSE, 8'hc0);
        outs(1'b1, 1'b1, 1'b0, 2'h0, 8'h55);
        wrs(LDC_OFS_LASER_CURRENT_CODE_INVERSE, 8'h55);
        outs(1'b0, 1'b1, 1'b0, 2'h0, 8'h55);
        wrs(LDC_OFS_LASER_CURRENT_CODE, 8'haa);
        outs(1'b1, 1'b1, 1'b0, 2'h0, 8'haa);
        wrs(LDC_OFS_LASER_CURRENT_CODE_INVERSE, 8'hff);
        wrs(LDC_OFS_LASER_CURRENT_CODE, 8'h00);
        outs(1'b1, 1'b1, 1'b0, 2'h0, 8'h00);
        wrs(LDC_OFS_LASER_CURRENT_CODE, 8'hff);
        wrs(LDC_OFS_LASER_CURRENT_CODE_INVERSE, 8'h00);
        outs(1'b1, 1'b1, 1'b0, 2'h0, 8'hff);
    endtask
    task automatic t_bands;
        logic [1:0] cs [4] = '{LDC_BAND_MID, LDC_BAND_HIGH, LDC_BAND_BAD, LDC_BAND_LOW};
        for (int i = 0; i < 4; i++)
        begin
            r = cs[i];
            wrs(LDC_OFS_LASER_CONTROL_PRIMARY, {r, 6'h00});
            wrs(LDC_OFS_LASER_RANGE_INVERSE, {~r, 6'h3f});
            if (r != LDC_BAND_BAD)
                lastb = r;
            outs(r != LDC_BAND_BAD, 1'b1, 1'b0, lastb, 8'hff);
            rdc(LDC_OFS_LASER_RANGE_INVERSE, {~r, 6'h00});
        end
        wrs(LDC_OFS_LASER_RANGE_INVERSE, 8'h00);
        outs(1'b0, 1'b1, 1'b0, 2'h0, 8'hff);
        wrs(LDC_OFS_LASER_RANGE_INVERSE, 8'hc0);
    endtask
    task automatic t_cal;
        logic [6:0] ma [2] = '{LDC_OFS_MOTION, LDC_OFS_MOTION_ALIAS};
        @(posedge i_clock);
        i_laser_pulse <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        outs(1'b1, 1'b0, 1'b0, 2'h0, 8'hff);
        @(posedge i_clock);
        i_laser_pulse <= 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        outs(1'b1, 1'b1, 1'b0, 2'h0, 8'hff);
        wrs(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h0a);
        outs(1'b1, 1'b0, 1'b1, 2'h0, 8'hff);
        wrs(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h0b);
        outs(1'b1, 1'b1, 1'b1, 2'h0, 8'hff);
        for (int i = 0; i < 2; i++)
        begin
            wrs(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h0a);
            u_mcu.rd(ma[i], v);
            @(posedge i_clock);
            #1;
            outs(1'b1, 1'b1, 1'b0, 2'h0, 8'hff);
            rdc(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h00);
        end
        wrs(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h3a);
        rdc(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h0a);
        wrs(LDC_OFS_LASER_CONTROL_PRIMARY, 8'h00);
        outs(1'b1, 1'b1, 1'b0, 2'h0, 8'hff);
        rdc(7'h1b, LDC_UNMAPPED_READ);
    endtask
    // =========================================================
    // main sequence
    initial
    begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    initial
    begin
        i_rst_n       = 1'b0;
        i_laser_pulse = 1'b0;
        fail_count    = 0;
        cmp_count     = 0;
        lastb         = 2'h0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        #1;
        t_reset();
        t_pairs();
        t_bands();
        t_cal();
        close_out();
    end
    // hang guard, far beyond the real run
    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
